/* cpu8_exec_datapath.sv */
// Byte execution datapath with standby control behind an AXI4-Lite slave
// How it works
// [RULE_01] Eight byte registers R0..R7, also four 16-bit pairs 0..3.
// [RULE_02] R1 is the byte accumulator, pair 0 the word accumulator.
// [RULE_03] Short direct addresses only FE20h..FF1Fh; word accesses there even only.
// [RULE_04] Absolute addresses span 64K; word transfers need even absolute address.
// [RULE_05] Bit operand is a 3-bit field picking one of eight bits.
// [RULE_06] Restore op reloads zero, aux carry, carry from saved status.
// [RULE_07] Each instruction clock is one CPU clock period chosen by divider.
// [RULE_08] Add writes sum to accumulator, sets Z, AC, CY; HL+byte 6 clocks.
// [RULE_09] Add with carry adds carry flag too, same flags and destination.
// [RULE_10] Subtract stores difference, carry is borrow; absolute form 8 clocks.
// [RULE_11] AND, OR, XOR change only zero; short direct immediate 6 clocks.
// [RULE_12] Byte increment in 4 clocks updates Z and AC, not carry.
// [RULE_13] Byte decrement likewise; word increment or decrement changes no flags.
// [RULE_14] Halt stops the CPU clock while oscillation keeps running.
// [RULE_15] Stop halts oscillation and every clocked operation.
// [RULE_16] Reset comes from the external pin or a watchdog runaway.
// [RULE_17] Rotates move shifted-out bit to carry; through-carry inserts old carry.
// [RULE_18] Compare updates Z, AC, CY but writes no result.
// [RULE_19] Interrupt or reset releases standby; stop waits for oscillator first; a reset here leaves stop at once, without the wait.
`timescale 1ns/1ps
module cpu8_exec_datapath
  import cpu8_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  input wire logic wdt_runaway,
  output logic osc_enable_q,
  output logic cpu_clk_run_q,
  output logic wdt_reset_q
);
  import cpu8_pkg::*;

  logic irq_lvl;
  logic wdt_lvl;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0][7:0] regs_q;
  logic [7:0] psw_q;
  logic [7:0] saved_q;
  logic [1:0] pcc_q;
  logic [2:0] div_q;
  logic [31:0] cmd_q;
  logic [31:0] opnd_q;
  logic [8:0] result_q;
  logic [3:0] remain_q;
  logic [7:0][7:0] pend_regs_q;
  logic [7:0] pend_psw_q;
  logic [8:0] pend_mem_q;
  op_type pend_op_q;
  logic addr_err_q;
  logic wdt_seen_q;
  stby_type stby_q;
  logic [7:0] wait_q;
  logic wr_fire;
  logic wr_bad;
  logic [31:0] wr_val;
  logic busy;
  logic tick;
  logic commit;
  logic issue;
  logic [2:0] div_mask;
  cmd_type cmd;
  logic [7:0][7:0] ex_regs;
  logic [7:0] ex_psw;
  logic [8:0] ex_mem;
  logic [3:0] ex_clocks;
  logic ex_bad;

  level_sync irq_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(irq_req),
    .level_q(irq_lvl)
  );

  level_sync wdt_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(wdt_runaway),
    .level_q(wdt_lvl)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [3:0] form_clocks(input form_type f);
    case (f)
      FORM_SADDR_IMM: form_clocks = CLK_SADDR_IMM; // [RULE_11]
      FORM_ABS: form_clocks = CLK_ABS; // [RULE_10]
      FORM_HL, FORM_HLB: form_clocks = CLK_HL; // [RULE_08]
      default: form_clocks = CLK_REG;
    endcase
  endfunction

  // Write channel: address and data may arrive in either order
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_bad = (awaddr_q > OFS_LAST) || (awaddr_q[1:0] != 2'b00);
  assign busy = (remain_q != 4'h0);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_wready <= 1'b1;
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one-cycle answer from the registered mux
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr > OFS_LAST || s_axi_araddr[1:0] != 2'b00) begin
        s_axi_rresp <= RESP_SLVERR;
      end else if (s_axi_araddr >= OFS_REG0) begin
        s_axi_rdata[7:0] <= regs_q[s_axi_araddr[4:2]];
      end else begin
        case (s_axi_araddr)
          OFS_CMD: s_axi_rdata <= cmd_q;
          OFS_OPND: s_axi_rdata <= opnd_q;
          OFS_STATUS: s_axi_rdata <= {20'h0_0000, remain_q, 3'h0, wdt_seen_q, addr_err_q,
                                      stby_q == STBY_STOP, stby_q == STBY_HALT, busy};
          OFS_PSW: s_axi_rdata[7:0] <= psw_q;
          OFS_SAVED: s_axi_rdata[7:0] <= saved_q;
          OFS_PCC: s_axi_rdata[1:0] <= pcc_q;
          OFS_STBY: s_axi_rdata[1:0] <= stby_q;
          OFS_RESULT: s_axi_rdata[8:0] <= result_q;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Instruction clock: one tick per CPU clock period, gated in standby
  assign div_mask = 3'((4'h1 << pcc_q) - 4'h1);
  assign tick = (stby_q == STBY_RUN) && ((div_q & div_mask) == div_mask); // [RULE_07] [RULE_14]
  assign commit = tick && (remain_q == 4'h1);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 3'h0;
    end else if (wdt_lvl) begin
      div_q <= 3'h0;
    end else if (stby_q == STBY_RUN) begin
      div_q <= div_q + 3'h1;
    end
  end

  // Command decode and evaluation against the current state
  assign wr_val = merge(aw_got_q && awaddr_q == OFS_CMD ? cmd_q : opnd_q, wdata_q, wstrb_q);
  assign cmd = cmd_type'({wr_val[22:20], wr_val[17:16], wr_val[14:12], // [RULE_05]
                          wr_val[10:8], wr_val[4:0]});
  assign issue = wr_fire && awaddr_q == OFS_CMD && !busy && stby_q == STBY_RUN;

  always_comb begin
    logic [7:0] acc;
    logic [7:0] src;
    logic [7:0] lhs;
    logic [7:0] res;
    logic [8:0] sum;
    logic [4:0] sum_lo;
    logic [8:0] dif;
    logic [4:0] dif_lo;
    logic [15:0] pair;
    logic [15:0] addr;
    logic cin;
    logic mem_dst;
    acc = regs_q[ACC_IDX]; // [RULE_02]
    cin = (cmd.op == OP_ADDC || cmd.op == OP_SUBC) && psw_q[PSW_CY]; // [RULE_09]
    mem_dst = cmd.form == FORM_SADDR_IMM;
    src = (cmd.form == FORM_REG) ? regs_q[cmd.r] : opnd_q[7:0]; // [RULE_01]
    lhs = mem_dst ? opnd_q[15:8] : acc;
    sum = {1'b0, lhs} + {1'b0, src} + {8'h00, cin};
    sum_lo = {1'b0, lhs[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    dif = {1'b0, lhs} - {1'b0, src} - {8'h00, cin};
    dif_lo = {1'b0, lhs[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
    pair = {regs_q[{cmd.rp, 1'b1}], regs_q[{cmd.rp, 1'b0}]}; // [RULE_01]
    addr = opnd_q[31:16];
    res = 8'h00;
    ex_regs = regs_q;
    ex_psw = psw_q;
    ex_mem = 9'h000;
    ex_clocks = form_clocks(cmd.form);
    ex_bad = 1'b0;
    if (cmd.form == FORM_SADDR || cmd.form == FORM_SADDR_IMM) begin
      ex_bad = addr < SADDR_LO || addr > SADDR_HI || (cmd.op == OP_MOVW && addr[0]); // [RULE_03]
    end else if (cmd.form == FORM_ABS) begin
      ex_bad = cmd.op == OP_MOVW && addr[0]; // [RULE_04]
    end
    case (cmd.op)
      OP_MOV: ex_regs[ACC_IDX] = src;
      OP_XCH: begin
        ex_regs[ACC_IDX] = src;
        if (cmd.form == FORM_REG) begin
          ex_regs[cmd.r] = acc;
        end else begin
          ex_mem = {1'b1, acc};
        end
      end
      OP_ADD, OP_ADDC: begin
        res = sum[7:0];
        ex_psw[PSW_AC] = sum_lo[4];
        ex_psw[PSW_CY] = sum[8]; // [RULE_08] [RULE_09]
      end
      OP_SUB, OP_SUBC, OP_CMP: begin
        res = dif[7:0];
        ex_psw[PSW_AC] = dif_lo[4];
        ex_psw[PSW_CY] = dif[8]; // [RULE_10] [RULE_18]
      end
      OP_AND: res = lhs & src; // [RULE_11]
      OP_OR: res = lhs | src;
      OP_XOR: res = lhs ^ src;
      OP_INC, OP_DEC: begin
        lhs = cmd.form == FORM_SADDR ? opnd_q[15:8] : regs_q[cmd.r];
        res = cmd.op == OP_INC ? lhs + 8'h01 : lhs - 8'h01;
        ex_psw[PSW_AC] = cmd.op == OP_INC ? lhs[3:0] == 4'hF : lhs[3:0] == 4'h0; // [RULE_12]
        ex_psw[PSW_Z] = res == 8'h00; // [RULE_13]
        ex_clocks = CLK_REG;
        if (cmd.form == FORM_SADDR) begin
          ex_mem = {1'b1, res};
        end else begin
          ex_regs[cmd.r] = res;
        end
      end
      OP_INCW, OP_DECW: begin
        pair = cmd.op == OP_INCW ? pair + 16'h0001 : pair - 16'h0001; // [RULE_13]
        {ex_regs[{cmd.rp, 1'b1}], ex_regs[{cmd.rp, 1'b0}]} = pair;
        ex_clocks = CLK_REG;
      end
      OP_MOVW: begin
        if (cmd.form == FORM_IMM) begin
          {ex_regs[{cmd.rp, 1'b1}], ex_regs[{cmd.rp, 1'b0}]} = opnd_q[15:0];
          ex_clocks = CLK_WORD_IMM;
        end else begin
          {ex_regs[ACC_IDX], ex_regs[3'h0]} = opnd_q[15:0]; // [RULE_02]
        end
      end
      OP_ROR, OP_RORC: begin
        ex_regs[ACC_IDX] = {cmd.op == OP_ROR ? acc[0] : psw_q[PSW_CY], acc[7:1]};
        ex_psw[PSW_CY] = acc[0]; // [RULE_17]
        ex_clocks = CLK_ROT;
      end
      OP_ROL, OP_ROLC: begin
        ex_regs[ACC_IDX] = {acc[6:0], cmd.op == OP_ROL ? acc[7] : psw_q[PSW_CY]};
        ex_psw[PSW_CY] = acc[7]; // [RULE_17]
        ex_clocks = CLK_ROT;
      end
      OP_RESTORE: begin
        ex_psw[PSW_Z] = saved_q[PSW_Z]; // [RULE_06]
        ex_psw[PSW_AC] = saved_q[PSW_AC];
        ex_psw[PSW_CY] = saved_q[PSW_CY];
      end
      OP_SET1: ex_regs[ACC_IDX][cmd.bitpos] = 1'b1; // [RULE_05]
      OP_CLR1: ex_regs[ACC_IDX][cmd.bitpos] = 1'b0;
      default: ex_clocks = CLK_ROT;
    endcase
    if (cmd.op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_AND, OP_OR, OP_XOR, OP_CMP}) begin
      ex_psw[PSW_Z] = res == 8'h00;
      if (cmd.op == OP_CMP) begin
        ex_mem = 9'h000; // [RULE_18]
      end else if (mem_dst) begin
        ex_mem = {1'b1, res};
      end else begin
        ex_regs[ACC_IDX] = res;
      end
    end
  end

  // Issue latches the outcome; it lands after the counted clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      remain_q <= 4'h0;
      pend_regs_q <= '0;
      pend_psw_q <= 8'h00;
      pend_mem_q <= 9'h000;
      pend_op_q <= OP_MOV;
    end else if (wdt_lvl) begin
      remain_q <= 4'h0; // [RULE_16]
    end else if (issue && !ex_bad) begin
      remain_q <= ex_clocks;
      pend_regs_q <= ex_regs;
      pend_psw_q <= ex_psw;
      pend_mem_q <= ex_mem;
      pend_op_q <= cmd.op;
    end else if (tick && busy) begin
      remain_q <= remain_q - 4'h1; // [RULE_07]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regs_q <= '0;
    end else if (wdt_lvl) begin
      regs_q <= '0;
    end else if (commit) begin
      regs_q <= pend_regs_q;
    end else if (wr_fire && !busy && !wr_bad && awaddr_q >= OFS_REG0 && wstrb_q[0]) begin
      regs_q[awaddr_q[4:2]] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      psw_q <= 8'h00;
      saved_q <= 8'h00;
      result_q <= 9'h000;
    end else if (wdt_lvl) begin
      psw_q <= 8'h00;
      saved_q <= 8'h00;
      result_q <= 9'h000;
    end else if (commit) begin
      psw_q <= pend_psw_q;
      result_q <= pend_mem_q;
    end else if (wr_fire && !busy && wstrb_q[0]) begin
      if (awaddr_q == OFS_PSW) begin
        psw_q <= wdata_q[7:0];
      end
      if (awaddr_q == OFS_SAVED) begin
        saved_q <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= 32'h0000_0000;
      opnd_q <= 32'h0000_0000;
      pcc_q <= 2'h0;
    end else if (wdt_lvl) begin
      pcc_q <= 2'h0;
    end else if (wr_fire) begin
      if (issue) begin
        cmd_q <= wr_val;
      end
      if (awaddr_q == OFS_OPND && !busy) begin
        opnd_q <= wr_val;
      end
      if (awaddr_q == OFS_PCC && wstrb_q[0]) begin
        pcc_q <= wdata_q[1:0];
      end
    end
  end

  // Sticky flags: a new event wins over a software clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_err_q <= 1'b0;
      wdt_seen_q <= 1'b0;
    end else begin
      if (issue && ex_bad) begin
        addr_err_q <= 1'b1; // [RULE_03] [RULE_04]
      end else if (wr_fire && awaddr_q == OFS_STATUS && wstrb_q[0] && wdata_q[ST_ADDR_ERR]) begin
        addr_err_q <= 1'b0;
      end
      if (wdt_lvl) begin
        wdt_seen_q <= 1'b1; // [RULE_16]
      end else if (wr_fire && awaddr_q == OFS_STATUS && wstrb_q[0] && wdata_q[ST_WDT]) begin
        wdt_seen_q <= 1'b0;
      end
    end
  end

  // Standby sequencing; oscillator settles before an interrupt out of stop resumes execution
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stby_q <= STBY_RUN;
      wait_q <= 8'h00;
    end else if (wdt_lvl) begin
      stby_q <= STBY_RUN; // [RULE_19]
    end else begin
      case (stby_q)
        STBY_RUN: begin
          if (wr_fire && awaddr_q == OFS_STBY && !busy && wstrb_q[0]) begin
            if (wdata_q[1:0] == STBY_HALT) begin
              stby_q <= STBY_HALT; // [RULE_14]
            end else if (wdata_q[1:0] == STBY_STOP) begin
              stby_q <= STBY_STOP; // [RULE_15]
            end
          end
        end
        STBY_HALT: if (irq_lvl) begin
          stby_q <= STBY_RUN; // [RULE_19]
        end
        STBY_STOP: if (irq_lvl) begin
          stby_q <= STBY_WAKE;
          wait_q <= OSC_WAIT_CYC;
        end
        STBY_WAKE: begin
          wait_q <= wait_q - 8'h01;
          if (wait_q == 8'h01) begin
            stby_q <= STBY_RUN; // [RULE_19]
          end
        end
        default: stby_q <= STBY_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_enable_q <= 1'b1;
      cpu_clk_run_q <= 1'b1;
      wdt_reset_q <= 1'b0;
    end else begin
      osc_enable_q <= stby_q != STBY_STOP; // [RULE_15]
      cpu_clk_run_q <= stby_q == STBY_RUN; // [RULE_14]
      wdt_reset_q <= wdt_lvl; // [RULE_16]
    end
  end

  halt_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_14]
    stby_q == STBY_HALT |-> !tick && osc_enable_q) else $error("tick during halt");
  stop_osc_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_15]
    stby_q == STBY_STOP |=> !osc_enable_q) else $error("oscillator on in stop");
  saddr_range_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_03]
    issue && ex_bad |=> addr_err_q && !busy) else $error("bad address executed");
  clock_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_07]
    tick && busy && !wdt_lvl |=> remain_q == $past(remain_q) - 4'h1)
    else $error("instruction clock miscounted");
  logic_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_11]
    commit && pend_op_q inside {OP_AND, OP_OR, OP_XOR} && !wdt_lvl
    |=> psw_q[PSW_CY] == $past(psw_q[PSW_CY]) && psw_q[PSW_AC] == $past(psw_q[PSW_AC]))
    else $error("logic op touched carry");
  wordinc_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_13]
    commit && pend_op_q inside {OP_INCW, OP_DECW} && !wdt_lvl |=> $stable(psw_q))
    else $error("word step changed flags");
  restore_psw_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_06]
    commit && pend_op_q == OP_RESTORE && !wdt_lvl
    |=> psw_q[PSW_CY] == saved_q[PSW_CY] && psw_q[PSW_Z] == saved_q[PSW_Z]
    && psw_q[PSW_AC] == saved_q[PSW_AC])
    else $error("flags not restored");
  wdt_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_16]
    wdt_lvl |=> !busy && stby_q == STBY_RUN && wdt_reset_q) else $error("runaway not reset");
  cmp_nowrite_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_18]
    commit && pend_op_q == OP_CMP && !wdt_lvl |=> regs_q == $past(regs_q) && !result_q[8])
    else $error("compare wrote result");
  halt_wake_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE_19]
    stby_q == STBY_HALT && irq_lvl |=> stby_q == STBY_RUN) else $error("halt not released");
endmodule

/* cpu8_exec_datapath_tb.sv */
// Directed bench for the byte datapath over its AXI4-Lite port
`timescale 1ns/1ps
module cpu8_exec_datapath_tb;
  import cpu8_pkg::*;
  logic sys_clk = 0, arst_n = 0, irq_req = 0, wdt_runaway = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic [1:0] bresp, rresp, rresp_q, bresp_q;
  logic awready, wready, bvalid, arready, rvalid, osc_en, cpu_run, wdt_rst;
  int bad_count = 0, total_checks = 0;
  localparam logic [7:0] A_OFS = OFS_REG0 + 8'h04;
  cpu8_exec_datapath uut (.sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_req(irq_req),
    .wdt_runaway(wdt_runaway), .osc_enable_q(osc_en), .cpu_clk_run_q(cpu_run),
    .wdt_reset_q(wdt_rst));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    // Valids drop only at their own handshake edge
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bresp_q = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd_q = rdata; rresp_q = rresp; rready <= 0;
  endtask
  task automatic run(input logic [4:0] op, input logic [2:0] f, input logic [3:0] r,
                     input logic [31:0] opnd);
    wr(OFS_OPND, opnd);
    wr(OFS_CMD, {16'h0, 1'b0, r[2:0], 1'b0, f, 3'h0, op} | {14'h0, r[3], 17'h0});
    // Bounded poll; busy must clear well inside an 8-clock instruction
    repeat (40) begin
      rd(OFS_STATUS);
      if (rd_q[ST_BUSY] === 1'b0) break;
    end
    chk(rd_q[ST_BUSY], 1'b0);
  endtask
  task automatic step(input logic [4:0] op, input logic [2:0] f, input logic [3:0] r,
                      input logic [7:0] opnd, input logic [7:0] ea, input logic [7:0] ep);
    run(op, f, r, {24'h0, opnd});
    rd(A_OFS);
    chk(rd_q, {24'h0, ea});
    rd(OFS_PSW);
    chk(rd_q, {24'h0, ep});
  endtask
  task automatic alu_test;
    wr(A_OFS, 8'h8F);
    step(OP_ADD, FORM_IMM, 4'h0, 8'h71, 8'h00, 8'h51);
    step(OP_ADDC, FORM_IMM, 4'h0, 8'h0E, 8'h0F, 8'h00);
    step(OP_SUB, FORM_IMM, 4'h0, 8'h10, 8'hFF, 8'h01);
    step(OP_AND, FORM_IMM, 4'h0, 8'h00, 8'h00, 8'h41);
    step(OP_INC, FORM_REG, 4'h1, 8'h00, 8'h01, 8'h01);
    step(OP_ROLC, FORM_REG, 4'h1, 8'h00, 8'h03, 8'h00);
    step(OP_CMP, FORM_IMM, 4'h0, 8'h03, 8'h03, 8'h40);
    wr(OFS_REG0, 8'hFF);
    step(OP_INCW, FORM_REG, 4'h0, 8'h00, 8'h04, 8'h40);
    step(OP_DEC, FORM_REG, 4'h1, 8'h00, 8'h03, 8'h00);
    wr(OFS_SAVED, 8'h11);
    step(OP_RESTORE, FORM_REG, 4'h1, 8'h00, 8'h03, 8'h11);
    // Short direct address just below the window must be refused
    run(OP_ADD, FORM_SADDR, 4'h0, 32'hFE1F_0001);
    chk(rd_q[ST_ADDR_ERR], 1'b1);
    rd(A_OFS);
    chk(rd_q, 32'h0000_0003);
    // Exchange in register form with R0 moves the old accumulator into R0
    step(OP_XCH, FORM_REG, 4'h0, 8'h00, 8'h00, 8'h11);
    rd(OFS_REG0);
    chk(rd_q, 32'h0000_0003);
    rd(8'h40);
    chk(rresp_q, RESP_SLVERR);
    wr(8'h40, 32'h0000_0000);
    chk(bresp_q, RESP_SLVERR);
    $display("alu test done");
  endtask
  task automatic standby_test;
    wr(OFS_STBY, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk({cpu_run, osc_en}, 2'b01);
    irq_req <= 1;
    repeat (10) @(posedge sys_clk);
    rd(OFS_STBY);
    chk(rd_q, 32'h0000_0000);
    irq_req <= 0;
    repeat (6) @(posedge sys_clk);
    wr(OFS_STBY, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk({cpu_run, osc_en}, 2'b00);
    irq_req <= 1;
    // Oscillator wait is 100 cycles before the CPU clock returns
    repeat (130) @(posedge sys_clk);
    irq_req <= 0;
    chk({cpu_run, osc_en}, 2'b11);
    $display("standby test done");
  endtask
  task automatic reset_test;
    wdt_runaway <= 1;
    repeat (8) @(posedge sys_clk);
    chk(wdt_rst, 1'b1);
    wdt_runaway <= 0;
    repeat (8) @(posedge sys_clk);
    chk(wdt_rst, 1'b0);
    rd(OFS_REG0);
    chk(rd_q, 32'h0000_0000);
    rd(OFS_STATUS);
    chk(rd_q[ST_WDT], 1'b1);
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1;
    alu_test();
    standby_test();
    reset_test();
    print_verdict();
  end
  initial begin
    // Whole run needs well under a thousand cycles
    #200_000;
    bad_count++;
    print_verdict();
  end
endmodule

/* cpu8_pkg.sv */
// Shared constants, encodings and carriers for the byte execution datapath
package cpu8_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PSW = 8'h0C;
  localparam logic [7:0] OFS_SAVED = 8'h10;
  localparam logic [7:0] OFS_PCC = 8'h14;
  localparam logic [7:0] OFS_STBY = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1C;
  localparam logic [7:0] OFS_REG0 = 8'h20;
  localparam logic [7:0] OFS_LAST = 8'h3C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] SADDR_LO = 16'hFE20;
  localparam logic [15:0] SADDR_HI = 16'hFF1F;
  localparam logic [2:0] ACC_IDX = 3'h1;
  localparam int PSW_Z = 6;
  localparam int PSW_AC = 4;
  localparam int PSW_CY = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_HALT = 1;
  localparam int ST_STOP = 2;
  localparam int ST_ADDR_ERR = 3;
  localparam int ST_WDT = 4;
  localparam logic [3:0] CLK_ROT = 4'h2;
  localparam logic [3:0] CLK_REG = 4'h4;
  localparam logic [3:0] CLK_SADDR_IMM = 4'h6;
  localparam logic [3:0] CLK_ABS = 4'h8;
  localparam logic [3:0] CLK_HL = 4'h6;
  localparam logic [3:0] CLK_WORD_IMM = 4'h6;
  localparam int unsigned OSC_WAIT_NS = 1000;
  localparam logic [7:0] OSC_WAIT_CYC = 8'(OSC_WAIT_NS * (CLK_HZ / 1_000_000) / 1000);

  typedef enum logic [4:0] {
    OP_MOV = 5'h00, OP_XCH = 5'h01, OP_ADD = 5'h02, OP_ADDC = 5'h03,
    OP_SUB = 5'h04, OP_SUBC = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
    OP_XOR = 5'h08, OP_CMP = 5'h09, OP_INC = 5'h0A, OP_DEC = 5'h0B,
    OP_INCW = 5'h0C, OP_DECW = 5'h0D, OP_MOVW = 5'h0E, OP_ROR = 5'h0F,
    OP_ROL = 5'h10, OP_RORC = 5'h11, OP_ROLC = 5'h12, OP_RESTORE = 5'h13,
    OP_SET1 = 5'h14, OP_CLR1 = 5'h15
  } op_type;

  typedef enum logic [2:0] {
    FORM_IMM = 3'h0, FORM_SADDR_IMM = 3'h1, FORM_REG = 3'h2, FORM_SADDR = 3'h3,
    FORM_ABS = 3'h4, FORM_HL = 3'h5, FORM_HLB = 3'h6
  } form_type;

  typedef enum logic [1:0] {
    STBY_RUN = 2'h0, STBY_HALT = 2'h1, STBY_STOP = 2'h2, STBY_WAKE = 2'h3
  } stby_type;

  typedef struct packed {
    logic [2:0] bitpos;
    logic [1:0] rp;
    logic [2:0] r;
    form_type form;
    op_type op;
  } cmd_type;
endpackage

/* level_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module level_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic din,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts only once two late stages agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule
